// [hdl/sbc_bank_state.sv]
`timescale 1ns/1ps

module sbc_bank_state
    import sbc_pkg::*;
#(
    parameter int MODE_SET_CYCLES = MODE_SET_CYCLES_DEF,
    parameter int BURST_LEN       = BURST_LEN_DEF
)(
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic                    clock_gate_in,
    input  wire logic                    chip_select_n,
    input  wire logic                    row_strobe_n,
    input  wire logic                    column_strobe_n,
    input  wire logic                    write_strobe_n,
    input  wire logic                    auto_precharge_sel,
    input  wire logic                    bank_sel_0,
    input  wire logic                    bank_sel_1,
    output logic [NUM_BANKS*4-1:0]       bank_state,
    output logic [2:0]                   device_state,
    output logic                         all_banks_idle,
    output logic                         command_taken,
    output logic                         illegal_command
);

    localparam logic [TIMER_W-1:0] PRE_LOAD   = TIMER_W'(PRECHARGE_CYCLES);
    localparam logic [TIMER_W-1:0] RCD_LOAD   = TIMER_W'(ROW_TO_COL_CYCLES);
    localparam logic [TIMER_W-1:0] RFC_LOAD   = TIMER_W'(REFRESH_CYCLES);
    localparam logic [TIMER_W-1:0] MRD_LOAD   = TIMER_W'(MODE_SET_CYCLES);
    localparam logic [TIMER_W-1:0] XSR_LOAD   = TIMER_W'(SELF_REFRESH_EXIT_CYCLES);
    localparam logic [TIMER_W-1:0] BURST_LOAD = TIMER_W'(BURST_LEN);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    function automatic logic [TIMER_W-1:0] count_down(input logic [TIMER_W-1:0] t);
        count_down = (t == TIMER_ZERO) ? TIMER_ZERO : t - TIMER_ONE;
    endfunction

    sbc_cmd_t        cmd;
    logic            gate_prev;
    logic            next_gate_prev;
    logic            gate_ok;
    logic [BANK_W-1:0] bank_addr;

    always_comb
    begin
        // Explicit table keeps the decode readable
        cmd = SBC_CMD_NOP;
        if (!chip_select_n)
        begin
            case ({row_strobe_n, column_strobe_n, write_strobe_n})
                3'b011:  cmd = SBC_CMD_ACTIVE;
                3'b101:  cmd = SBC_CMD_READ;
                3'b100:  cmd = SBC_CMD_WRITE;
                3'b010:  cmd = SBC_CMD_PRECHARGE;
                3'b110:  cmd = SBC_CMD_TERMINATE;
                3'b001:  cmd = SBC_CMD_REFRESH;
                3'b000:  cmd = SBC_CMD_LOAD_MODE;
                default: cmd = SBC_CMD_NOP;
            endcase
        end
    end

    assign bank_addr      = {bank_sel_1, bank_sel_0};
    assign next_gate_prev = clock_gate_in;

    // ------------------------------------------------------------
    // Device-wide state
    // ------------------------------------------------------------
    sbc_dev_state_t    dev;
    sbc_dev_state_t    next_dev;
    logic [TIMER_W-1:0] dev_timer;
    logic [TIMER_W-1:0] next_dev_timer;

    sbc_bank_state_t    bank   [NUM_BANKS];
    sbc_bank_state_t    next_bank [NUM_BANKS];
    logic [TIMER_W-1:0] btimer [NUM_BANKS];
    logic [TIMER_W-1:0] next_btimer [NUM_BANKS];
    logic [TIMER_W-1:0] burst  [NUM_BANKS];
    logic [TIMER_W-1:0] next_burst [NUM_BANKS];
    logic [BANK_W-1:0]  last_bank;
    logic [BANK_W-1:0]  next_last_bank;
    logic               last_valid;
    logic               next_last_valid;
    logic               idle_all;
    logic               any_busy;

    // Gate low drops commands; refresh on a falling gate is taken as self refresh entry
    assign gate_ok = gate_prev & clock_gate_in & (dev != SBC_DEV_SR_EXIT);

    always_comb
    begin
        idle_all = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++)
            if (bank[i] != SBC_BANK_IDLE)
                idle_all = 1'b0;
    end

    assign any_busy = (dev != SBC_DEV_NORMAL);

    always_comb
    begin
        next_dev       = dev;
        next_dev_timer = count_down(dev_timer);
        case (dev)
            SBC_DEV_NORMAL:
            begin
                if (gate_prev & ~clock_gate_in & (cmd == SBC_CMD_REFRESH) & idle_all)
                begin
                    // Self refresh entry: wait for gate to rise, then exit time
                    next_dev       = SBC_DEV_SR_EXIT;
                    next_dev_timer = XSR_LOAD;
                end
                else if (gate_ok & idle_all & (cmd == SBC_CMD_REFRESH))
                begin
                    next_dev       = SBC_DEV_REFRESHING;
                    next_dev_timer = RFC_LOAD;
                end
                else if (gate_ok & idle_all & (cmd == SBC_CMD_LOAD_MODE))
                begin
                    next_dev       = SBC_DEV_MODE_SET;
                    next_dev_timer = MRD_LOAD;
                end
                else if (gate_ok & (cmd == SBC_CMD_PRECHARGE) & auto_precharge_sel)
                begin
                    next_dev       = SBC_DEV_PRE_ALL;
                    next_dev_timer = PRE_LOAD;
                end
            end
            SBC_DEV_REFRESHING, SBC_DEV_MODE_SET, SBC_DEV_PRE_ALL:
            begin
                // Commands ignored until the timer runs out
                if (dev_timer <= TIMER_ONE)
                    next_dev = SBC_DEV_NORMAL;
            end
            SBC_DEV_SR_EXIT:
            begin
                if (!clock_gate_in)
                    next_dev_timer = XSR_LOAD;
                else if (dev_timer <= TIMER_ONE)
                    next_dev = SBC_DEV_NORMAL;
            end
            default:
                next_dev = SBC_DEV_NORMAL;
        endcase
    end

    // ------------------------------------------------------------
    // Per-bank state
    // ------------------------------------------------------------
    always_comb
    begin
        next_last_bank  = last_bank;
        next_last_valid = last_valid;
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            logic hit;
            hit            = gate_ok & ~any_busy & (bank_addr == BANK_W'(i));
            next_bank[i]   = bank[i];
            next_btimer[i] = count_down(btimer[i]);
            next_burst[i]  = count_down(burst[i]);
            case (bank[i])
                SBC_BANK_IDLE:
                begin
                    if (hit & (cmd == SBC_CMD_ACTIVE))
                    begin
                        next_bank[i]   = SBC_BANK_ACTIVATING;
                        next_btimer[i] = RCD_LOAD;
                    end
                    // Precharge to an idle bank falls through unchanged
                end
                SBC_BANK_ACTIVATING:
                    if (btimer[i] <= TIMER_ONE)
                        next_bank[i] = SBC_BANK_ROW_ACTIVE;
                SBC_BANK_PRECHARGING:
                    if (btimer[i] <= TIMER_ONE)
                        next_bank[i] = SBC_BANK_IDLE;
                SBC_BANK_READ_AP, SBC_BANK_WRITE_AP:
                begin
                    // Precharge timer starts when the burst ends
                    if (burst[i] != TIMER_ZERO)
                        next_btimer[i] = PRE_LOAD;
                    else if (btimer[i] <= TIMER_ONE)
                        next_bank[i] = SBC_BANK_IDLE;
                end
                SBC_BANK_ROW_ACTIVE, SBC_BANK_READ, SBC_BANK_WRITE:
                begin
                    if ((bank[i] != SBC_BANK_ROW_ACTIVE) & (burst[i] <= TIMER_ONE))
                        next_bank[i] = SBC_BANK_ROW_ACTIVE;
                    if (hit & ((cmd == SBC_CMD_READ) | (cmd == SBC_CMD_WRITE)))
                    begin
                        next_burst[i] = BURST_LOAD;
                        if (auto_precharge_sel)
                            next_bank[i] = (cmd == SBC_CMD_READ) ? SBC_BANK_READ_AP
                                                                 : SBC_BANK_WRITE_AP;
                        else
                            next_bank[i] = (cmd == SBC_CMD_READ) ? SBC_BANK_READ
                                                                 : SBC_BANK_WRITE;
                        next_last_bank  = BANK_W'(i);
                        next_last_valid = 1'b1;
                    end
                    else if (hit & (cmd == SBC_CMD_PRECHARGE) & ~auto_precharge_sel)
                    begin
                        next_bank[i]   = SBC_BANK_PRECHARGING;
                        next_btimer[i] = PRE_LOAD;
                        next_burst[i]  = TIMER_ZERO;
                    end
                end
                default:
                    next_bank[i] = SBC_BANK_IDLE;
            endcase
            // Precharge all
            if (gate_ok & ~any_busy & (cmd == SBC_CMD_PRECHARGE) & auto_precharge_sel)
            begin
                next_bank[i]   = SBC_BANK_IDLE;
                next_burst[i]  = TIMER_ZERO;
                next_btimer[i] = TIMER_ZERO;
            end
            // Burst terminate hits the newest burst only
            if (gate_ok & ~any_busy & (cmd == SBC_CMD_TERMINATE) & last_valid
                & (last_bank == BANK_W'(i))
                & ((bank[i] == SBC_BANK_READ) | (bank[i] == SBC_BANK_WRITE)))
            begin
                next_bank[i]  = SBC_BANK_ROW_ACTIVE;
                next_burst[i] = TIMER_ZERO;
            end
        end
        if (gate_ok & ~any_busy & (cmd == SBC_CMD_TERMINATE))
            next_last_valid = 1'b0;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            gate_prev  <= 1'b0;
            dev        <= SBC_DEV_NORMAL;
            dev_timer  <= TIMER_ZERO;
            last_bank  <= '0;
            last_valid <= 1'b0;
            for (int i = 0; i < NUM_BANKS; i++)
            begin
                bank[i]   <= SBC_BANK_IDLE;
                btimer[i] <= TIMER_ZERO;
                burst[i]  <= TIMER_ZERO;
            end
        end
        else
        begin
            gate_prev  <= next_gate_prev;
            dev        <= next_dev;
            dev_timer  <= next_dev_timer;
            last_bank  <= next_last_bank;
            last_valid <= next_last_valid;
            for (int i = 0; i < NUM_BANKS; i++)
            begin
                bank[i]   <= next_bank[i];
                btimer[i] <= next_btimer[i];
                burst[i]  <= next_burst[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    logic next_taken;
    logic next_illegal;
    logic taken_q;
    logic illegal_q;

    always_comb
    begin
        next_taken   = gate_ok & ~any_busy & (cmd != SBC_CMD_NOP);
        next_illegal = 1'b0;
        if (gate_ok & (cmd != SBC_CMD_NOP))
        begin
            if (any_busy)
                next_illegal = 1'b1;
            else if (((cmd == SBC_CMD_REFRESH) | (cmd == SBC_CMD_LOAD_MODE)) & ~idle_all)
                next_illegal = 1'b1;
            else if ((cmd == SBC_CMD_ACTIVE) & (bank[bank_addr] != SBC_BANK_IDLE))
                next_illegal = 1'b1;
            else if (((cmd == SBC_CMD_READ) | (cmd == SBC_CMD_WRITE))
                     & ((bank[bank_addr] == SBC_BANK_IDLE)
                        | (bank[bank_addr] == SBC_BANK_ACTIVATING)
                        | (bank[bank_addr] == SBC_BANK_PRECHARGING)
                        | (bank[bank_addr] == SBC_BANK_READ_AP)
                        | (bank[bank_addr] == SBC_BANK_WRITE_AP)))
                next_illegal = 1'b1;
        end
        if (next_illegal)
            next_taken = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            taken_q   <= 1'b0;
            illegal_q <= 1'b0;
        end
        else
        begin
            taken_q   <= next_taken;
            illegal_q <= next_illegal;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_BANKS; i++)
            bank_state[i*4 +: 4] = bank[i];
    end

    assign device_state    = dev;
    assign all_banks_idle  = idle_all & (dev == SBC_DEV_NORMAL);
    assign command_taken   = taken_q;
    assign illegal_command = illegal_q;

endmodule // sbc_bank_state

// [hdl/sbc_pkg.sv]
package sbc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS      = 10;
    localparam int PRECHARGE_TIME_NS    = 20;
    localparam int ROW_TO_COL_DELAY_NS  = 20;
    localparam int REFRESH_CYCLE_NS     = 70;
    localparam int MODE_SET_CYCLES_DEF  = 2;
    localparam int SELF_REFRESH_EXIT_NS = 80;
    localparam int BURST_LEN_DEF        = 4;

    // Least times round up to whole cycles
    localparam int PRECHARGE_CYCLES =
        (PRECHARGE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int ROW_TO_COL_CYCLES =
        (ROW_TO_COL_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int REFRESH_CYCLES =
        (REFRESH_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SELF_REFRESH_EXIT_CYCLES =
        (SELF_REFRESH_EXIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    localparam int TIMER_W   = 8;
    localparam int NUM_BANKS = 4;
    localparam int BANK_W    = 2;

    localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'H00;
    localparam logic [TIMER_W-1:0] TIMER_ONE  = 8'H01;

    // ------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SBC_CMD_NOP       = 3'b000,
        SBC_CMD_ACTIVE    = 3'b001,
        SBC_CMD_READ      = 3'b010,
        SBC_CMD_WRITE     = 3'b011,
        SBC_CMD_PRECHARGE = 3'b100,
        SBC_CMD_TERMINATE = 3'b101,
        SBC_CMD_REFRESH   = 3'b110,
        SBC_CMD_LOAD_MODE = 3'b111
    } sbc_cmd_t;

    typedef enum logic [3:0] {
        SBC_BANK_IDLE        = 4'b0000,
        SBC_BANK_ACTIVATING  = 4'b0001,
        SBC_BANK_ROW_ACTIVE  = 4'b0010,
        SBC_BANK_READ        = 4'b0011,
        SBC_BANK_WRITE       = 4'b0100,
        SBC_BANK_READ_AP     = 4'b0101,
        SBC_BANK_WRITE_AP    = 4'b0110,
        SBC_BANK_PRECHARGING = 4'b0111
    } sbc_bank_state_t;

    typedef enum logic [2:0] {
        SBC_DEV_NORMAL     = 3'b000,
        SBC_DEV_REFRESHING = 3'b001,
        SBC_DEV_MODE_SET   = 3'b010,
        SBC_DEV_PRE_ALL    = 3'b011,
        SBC_DEV_SR_EXIT    = 3'b100
    } sbc_dev_state_t;

endpackage

// [test/sbc_bank_state_props.sv]
`timescale 1ns/1ps
module sbc_bank_state_props
    import sbc_pkg::*;
#(
    parameter int MODE_SET_CYCLES = MODE_SET_CYCLES_DEF
)(
    input wire logic                   clock,
    input wire logic                   rst,
    input wire logic                   clock_gate_in,
    input wire logic                   chip_select_n,
    input wire logic                   row_strobe_n,
    input wire logic                   column_strobe_n,
    input wire logic                   write_strobe_n,
    input wire logic                   auto_precharge_sel,
    input wire logic                   bank_sel_0,
    input wire logic                   bank_sel_1,
    input wire logic [NUM_BANKS*4-1:0] bank_state,
    input wire logic [2:0]             device_state,
    input wire logic                   all_banks_idle,
    input wire logic                   command_taken,
    input wire logic                   illegal_command
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    logic [2:0] strobes;
    logic [2:0] last_cmd;
    logic [1:0] last_bank;
    logic [3:0] last_state;
    logic [3:0] cur_state;
    logic [3:0] b0;
    logic       last_ap;

    assign strobes    = {row_strobe_n, column_strobe_n, write_strobe_n};
    assign last_state = bank_state[4*last_bank +: 4];
    assign cur_state  = bank_state[4*{bank_sel_1, bank_sel_0} +: 4];
    assign b0         = bank_state[3:0];

    always_ff @(posedge clock)
    begin
        last_cmd  <= strobes;
        last_bank <= {bank_sel_1, bank_sel_0};
        last_ap   <= auto_precharge_sel;
    end

    a_idle_no_reply:
        assert property ((chip_select_n || strobes == 3'H7) |=> !command_taken && !illegal_command)
        else $error("Deselect or no-op gave a reply");
    a_active_opens:
        assert property (command_taken && last_cmd == 3'H3 |-> last_state == SBC_BANK_ACTIVATING)
        else $error("Taken ACTIVE did not open the bank");
    a_activate_time:
        assert property ($rose(b0 == SBC_BANK_ACTIVATING) |->
            ##1 (b0 == SBC_BANK_ACTIVATING) ##1 (b0 == SBC_BANK_ROW_ACTIVE))
        else $error("Row activation length wrong");
    a_precharge_time:
        assert property ($rose(b0 == SBC_BANK_PRECHARGING) |->
            ##1 (b0 == SBC_BANK_PRECHARGING) ##1 (b0 == SBC_BANK_IDLE))
        else $error("Precharge length wrong");
    a_refresh_time:
        assert property ($rose(device_state == SBC_DEV_REFRESHING) |->
            (device_state == SBC_DEV_REFRESHING)[*7]
            ##1 (device_state == SBC_DEV_NORMAL && all_banks_idle))
        else $error("Refresh length wrong");
    a_mode_time:
        assert property ($rose(device_state == SBC_DEV_MODE_SET) |->
            ##MODE_SET_CYCLES (device_state == SBC_DEV_NORMAL && all_banks_idle))
        else $error("Mode access length wrong");
    a_gate_blocks:
        assert property (!clock_gate_in |=> !command_taken ##1 !command_taken)
        else $error("Command taken with gate low");
    a_busy_refuses:
        assert property (device_state != SBC_DEV_NORMAL && !chip_select_n && strobes != 3'H7
            |=> !command_taken)
        else $error("Command taken in device-wide state");
    a_pre_all:
        assert property (command_taken && last_cmd == 3'H2 && last_ap
            |-> bank_state == 16'H0000 && device_state == SBC_DEV_PRE_ALL)
        else $error("Precharge all not applied");
    a_idle_precharge:
        assert property (!chip_select_n && strobes == 3'H2 && !auto_precharge_sel
            && device_state == SBC_DEV_NORMAL && cur_state == SBC_BANK_IDLE
            |=> last_state == SBC_BANK_IDLE && !illegal_command)
        else $error("Precharge of idle bank changed it");

    c_pre_all:  cover property (device_state == SBC_DEV_PRE_ALL);
    c_refused:  cover property (illegal_command);
    c_write:    cover property ($rose(b0 == SBC_BANK_WRITE));
endmodule // sbc_bank_state_props

bind sbc_bank_state sbc_bank_state_props #(.MODE_SET_CYCLES(MODE_SET_CYCLES))
    sbc_bank_state_props_inst (
    .clock, .rst, .clock_gate_in, .chip_select_n, .row_strobe_n, .column_strobe_n,
    .write_strobe_n, .auto_precharge_sel, .bank_sel_0, .bank_sel_1, .bank_state,
    .device_state, .all_banks_idle, .command_taken, .illegal_command);

// [test/sbc_ctrl_model.sv]
`timescale 1ns/1ps
module sbc_ctrl_model
    import sbc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       req_valid,
    input  wire sbc_cmd_t   req_cmd,
    input  wire logic [1:0] req_bank,
    input  wire logic       req_ap,
    output logic            chip_select_n,
    output logic            row_strobe_n,
    output logic            column_strobe_n,
    output logic            write_strobe_n,
    output logic            auto_precharge_sel,
    output logic            bank_sel_0,
    output logic            bank_sel_1
);
    logic       churn = 1'B0;
    logic [2:0] code;

    // Lines left undriven flip every cycle
    always @(posedge clock)
        churn <= ~churn;

    always_comb
    begin
        case (req_cmd)
            SBC_CMD_ACTIVE:    code = 3'H3;
            SBC_CMD_READ:      code = 3'H5;
            SBC_CMD_WRITE:     code = 3'H4;
            SBC_CMD_PRECHARGE: code = 3'H2;
            SBC_CMD_TERMINATE: code = 3'H6;
            SBC_CMD_REFRESH:   code = 3'H1;
            SBC_CMD_LOAD_MODE: code = 3'H0;
            default:           code = 3'H7;
        endcase
        chip_select_n = !req_valid;
        {row_strobe_n, column_strobe_n, write_strobe_n} = req_valid ? code : {3{churn}};
        auto_precharge_sel = req_valid ? req_ap : churn;
        {bank_sel_1, bank_sel_0} = req_valid ? req_bank : {2{churn}};
    end
endmodule // sbc_ctrl_model

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import sbc_pkg::*;

    typedef struct packed {logic ill; logic [1:0] bank; logic [3:0] st;} sbc_note_t;

    logic        clock, rst, clock_gate_in, req_valid, req_ap, quiet;
    logic        chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n;
    logic        auto_precharge_sel, bank_sel_0, bank_sel_1;
    logic        all_banks_idle, command_taken, illegal_command;
    logic [1:0]  req_bank, b;
    logic [15:0] bank_state;
    logic [2:0]  device_state;
    sbc_cmd_t    req_cmd;
    sbc_note_t   notes[$];
    int          errors, cmp_count, seed;

    sbc_bank_state sbc_bank_state_inst (.clock, .rst, .clock_gate_in, .chip_select_n,
        .row_strobe_n, .column_strobe_n, .write_strobe_n, .auto_precharge_sel, .bank_sel_0,
        .bank_sel_1, .bank_state, .device_state, .all_banks_idle, .command_taken,
        .illegal_command);
    sbc_ctrl_model sbc_ctrl_model_inst (.clock, .req_valid, .req_cmd, .req_bank, .req_ap,
        .chip_select_n, .row_strobe_n, .column_strobe_n, .write_strobe_n,
        .auto_precharge_sel, .bank_sel_0, .bank_sel_1);

    initial
    begin
        clock = 1'B0;
        forever #5 clock = ~clock;
    end

    task automatic give_verdict;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cmp_state(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pulse(input sbc_note_t n);
        cmp_state({command_taken, illegal_command, 10'H000, bank_state[4*n.bank +: 4]},
                  {!n.ill, n.ill, 10'H000, n.st});
    endtask

    task automatic step(input int n);
        req_cmd = SBC_CMD_NOP;
        repeat (n) @(posedge clock);
        #1;
    endtask

    // State F: no reply expected
    task automatic issue(input sbc_cmd_t c, input logic [1:0] bk, input logic a,
                         input logic ill, input logic [3:0] st);
        req_valid = 1'B1;
        req_cmd = c;
        req_bank = bk;
        req_ap = a;
        if (st !== 4'HF)
            notes.push_back({ill, bk, st});
        @(posedge clock);
        #1;
    endtask

    task automatic wait_chk(input int n, input logic [1:0] bk, input logic [3:0] st);
        step(n);
        cmp_state(16'(bank_state[4*bk +: 4]), 16'(st));
    endtask

    // Replies are matched in order of issue
    always @(negedge clock)
        if (command_taken === 1'B1 || illegal_command === 1'B1)
        begin
            if (notes.size() > 0)
                cmp_pulse(notes.pop_front());
            else if (!quiet)
                cmp_state(16'H0001, 16'H0000);
        end

    initial
    begin
        #20000;
        errors++;
        give_verdict();
    end

    initial
    begin
        {errors, cmp_count, quiet, req_valid, req_ap, req_bank} = '0;
        clock_gate_in = 1'B1;
        rst = 1'B1;
        seed = 74;
        step(6);
        rst = 1'B0;
        step(2);
        // ---------------------------------------------------------
        // Read bursts, restart and cut short
        // ---------------------------------------------------------
        b = 2'($random(seed));
        issue(SBC_CMD_ACTIVE, b, 1'B0, 1'B0, SBC_BANK_ACTIVATING);
        wait_chk(1, b, SBC_BANK_ACTIVATING);
        wait_chk(1, b, SBC_BANK_ROW_ACTIVE);
        issue(SBC_CMD_READ, b, 1'B0, 1'B0, SBC_BANK_READ);
        step(1);
        issue(SBC_CMD_READ, b, 1'B0, 1'B0, SBC_BANK_READ);
        wait_chk(3, b, SBC_BANK_READ);
        issue(SBC_CMD_PRECHARGE, b, 1'B0, 1'B0, SBC_BANK_PRECHARGING);
        wait_chk(1, b, SBC_BANK_PRECHARGING);
        wait_chk(1, b, SBC_BANK_IDLE);
        // ---------------------------------------------------------
        // Write bursts, terminate and cut short
        // ---------------------------------------------------------
        issue(SBC_CMD_ACTIVE, 2'H0, 1'B0, 1'B0, SBC_BANK_ACTIVATING);
        step(2);
        issue(SBC_CMD_WRITE, 2'H0, 1'B0, 1'B0, SBC_BANK_WRITE);
        issue(SBC_CMD_TERMINATE, 2'H0, 1'B0, 1'B0, SBC_BANK_ROW_ACTIVE);
        issue(SBC_CMD_WRITE, 2'H0, 1'B0, 1'B0, SBC_BANK_WRITE);
        issue(SBC_CMD_PRECHARGE, 2'H0, 1'B0, 1'B0, SBC_BANK_PRECHARGING);
        wait_chk(2, 2'H0, SBC_BANK_IDLE);
        // ---------------------------------------------------------
        // Auto precharge on write and read
        // ---------------------------------------------------------
        for (int i = 0; i < 2; i++)
        begin
            b = 2'(2 + i);
            issue(SBC_CMD_ACTIVE, b, 1'B0, 1'B0, SBC_BANK_ACTIVATING);
            step(2);
            issue(i ? SBC_CMD_READ : SBC_CMD_WRITE, b, 1'B1, 1'B0,
                  i ? SBC_BANK_READ_AP : SBC_BANK_WRITE_AP);
            issue(i ? SBC_CMD_ACTIVE : SBC_CMD_READ, b, 1'B0, 1'B1,
                  i ? SBC_BANK_READ_AP : SBC_BANK_WRITE_AP);
            wait_chk(4, b, i ? SBC_BANK_READ_AP : SBC_BANK_WRITE_AP);
            wait_chk(1, b, SBC_BANK_IDLE);
        end
        // ---------------------------------------------------------
        // Precharge all, idle precharge, refused read
        // ---------------------------------------------------------
        issue(SBC_CMD_ACTIVE, 2'H0, 1'B0, 1'B0, SBC_BANK_ACTIVATING);
        issue(SBC_CMD_ACTIVE, 2'H2, 1'B0, 1'B0, SBC_BANK_ACTIVATING);
        step(2);
        issue(SBC_CMD_PRECHARGE, 2'H1, 1'B1, 1'B0, SBC_BANK_IDLE);
        cmp_state(bank_state, 16'H0000);
        cmp_state(16'(device_state), 16'(SBC_DEV_PRE_ALL));
        issue(SBC_CMD_ACTIVE, 2'H0, 1'B0, 1'B1, SBC_BANK_IDLE);
        step(1);
        cmp_state(16'(device_state), 16'(SBC_DEV_NORMAL));
        quiet = 1'B1;
        issue(SBC_CMD_PRECHARGE, b, 1'B0, 1'B0, 4'HF);
        cmp_state(16'({illegal_command, bank_state[4*b +: 4]}), 16'H0000);
        step(1);
        quiet = 1'B0;
        issue(SBC_CMD_READ, 2'H1, 1'B0, 1'B1, SBC_BANK_IDLE);
        // ---------------------------------------------------------
        // Refresh and mode access
        // ---------------------------------------------------------
        for (int i = 0; i < 2; i++)
        begin
            issue(i ? SBC_CMD_LOAD_MODE : SBC_CMD_REFRESH, 2'H0, 1'B0, 1'B0,
                  SBC_BANK_IDLE);
            issue(SBC_CMD_ACTIVE, 2'H1, 1'B0, 1'B1, SBC_BANK_IDLE);
            cmp_state(16'(device_state),
                      16'(i ? SBC_DEV_MODE_SET : SBC_DEV_REFRESHING));
            step(i ? 1 : 6);
            cmp_state({12'H000, all_banks_idle, device_state}, 16'H0008);
        end
        // ---------------------------------------------------------
        // Clock gate low blocks commands
        // ---------------------------------------------------------
        clock_gate_in = 1'B0;
        issue(SBC_CMD_REFRESH, 2'H0, 1'B0, 1'B0, 4'HF);
        issue(SBC_CMD_ACTIVE, 2'H1, 1'B0, 1'B0, 4'HF);
        clock_gate_in = 1'B1;
        issue(SBC_CMD_ACTIVE, 2'H1, 1'B0, 1'B0, 4'HF);
        wait_chk(1, 2'H1, SBC_BANK_IDLE);
        cmp_state(16'(device_state), 16'(SBC_DEV_SR_EXIT));
        step(6);
        cmp_state(16'(device_state), 16'(SBC_DEV_NORMAL));
        issue(SBC_CMD_ACTIVE, 2'H1, 1'B0, 1'B0, SBC_BANK_ACTIVATING);
        step(4);
        cmp_state(16'(notes.size()), 16'H0000);
        give_verdict();
    end
endmodule // testbench
